// ===== core/dpa_pkg.sv
package dpa_pkg;
	// Address and data widths of the shared memory.
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	// Mailbox locations: right port owns the top word, left the one below.
	localparam logic [9:0] RIGHT_MAILBOX_ADDR = 10'h3ff;
	localparam logic [9:0] LEFT_MAILBOX_ADDR = 10'h3fe;
	// Clock period in picoseconds.
	localparam int CLK_PERIOD_PS = 10000;
	// Device timing in nanoseconds, slower grade.
	localparam int BUSY_FROM_MATCH_DELAY_NS = 20;
	localparam int MIN_WRITE_PULSE_WIDTH_NS = 15;
	localparam int WRITE_PULSE_TO_DATA_DELAY_NS = 40;
	localparam int ADDR_SETUP_NS = 0;
	// Least times round up to whole cycles; a zero time gives zero cycles.
	localparam int BUSY_WAIT_CYC =
		(BUSY_FROM_MATCH_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PULSE_CYC =
		(MIN_WRITE_PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DATA_WAIT_CYC =
		(WRITE_PULSE_TO_DATA_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int CNT_W = 4;

	// User-side request.
	typedef struct packed {
		logic write;
		logic [9:0] addr;
		logic [7:0] wdata;
	} dpa_req_type;

	// Pins toward one device port.
	typedef struct packed {
		logic ce_n;
		logic rw_n;
		logic oe_n;
		logic [9:0] addr;
	} dpa_pins_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETTLE,
		ST_STROBE,
		ST_BUSY_WAIT,
		ST_EXTEND,
		ST_DONE
	} dpa_state_type;
endpackage : dpa_pkg

// ===== core/dpa_host_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Host seeing busy waits for release, then extends its operation.
// - Losing writer holding strobe a pulse width after busy succeeds.
// - Width expansion uses one master only, never two in parallel.
// - Slave write strobes are delayed at least the busy delay.
module dpa_host_port (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire dpa_pkg::dpa_req_type req,
	output logic req_ready,
	output logic done,
	output logic [7:0] rdata,
	output logic mailbox_irq,
	output dpa_pkg::dpa_pins_type pins,
	output logic slave_rw_n,
	output logic [7:0] data_out,
	output logic data_oe_n,
	input wire logic [7:0] data_in,
	input wire logic busy_n,
	input wire logic mailbox_irq_n,
	input wire logic own_mailbox_is_top
);
	import dpa_pkg::*;

	dpa_state_type state;
	dpa_req_type cur;
	logic [CNT_W-1:0] cnt;
	logic busy_seen;
	dpa_state_type next_state;
	logic [CNT_W-1:0] next_cnt;

	// The address that this host reads to clear its own interrupt.
	function automatic logic [9:0] own_box(input logic top);
		own_box = top ? RIGHT_MAILBOX_ADDR : LEFT_MAILBOX_ADDR;
	endfunction : own_box

	wire logic start = (state == ST_IDLE) && req_valid;
	wire logic cnt_zero = (cnt == '0);
	// Busy from a master or routed to a slave looks the same here.
	wire logic busy_now = !busy_n;
	wire logic [CNT_W-1:0] strobe_len = cur.write ?
		CNT_W'(PULSE_CYC) : CNT_W'(DATA_WAIT_CYC);
	wire logic is_own_box = (cur.addr == own_box(own_mailbox_is_top));

	// Sequencer: settle, strobe, and on busy wait then extend a full pulse.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
		ST_IDLE: begin
			if (start) begin
				next_state = ST_SETTLE;
				next_cnt = CNT_W'(BUSY_WAIT_CYC);
			end
		end
		ST_SETTLE: begin
			// Let arbitration resolve before the strobe falls.
			if (cnt_zero) begin
				next_state = ST_STROBE;
				next_cnt = strobe_len;
			end else begin
				next_cnt = cnt - 1'b1;
			end
		end
		ST_STROBE: begin
			if (busy_now) begin
				next_state = ST_BUSY_WAIT;
			end else if (cnt_zero) begin
				next_state = busy_seen ? ST_EXTEND : ST_DONE;
				next_cnt = strobe_len;
			end else begin
				next_cnt = cnt - 1'b1;
			end
		end
		ST_BUSY_WAIT: begin
			// Strobe stays low; the losing write is held off.
			if (!busy_now) begin
				next_state = ST_EXTEND;
				next_cnt = strobe_len;
			end
		end
		ST_EXTEND: begin
			// Hold one more full pulse after busy clears.
			if (busy_now) begin
				next_state = ST_BUSY_WAIT;
			end else if (cnt_zero) begin
				next_state = ST_DONE;
			end else begin
				next_cnt = cnt - 1'b1;
			end
		end
		ST_DONE: next_state = ST_IDLE;
		default: next_state = ST_IDLE;
		endcase
	end

	wire logic strobing = (next_state == ST_STROBE) ||
		(next_state == ST_BUSY_WAIT) || (next_state == ST_EXTEND);
	wire logic active = strobing || (next_state == ST_SETTLE);
	// The operation of the access being set up; a fresh request is not in
	// cur until the edge that takes it, so the data drive looks at req.
	wire logic op_write = start ? req.write : cur.write;
	// Data is sampled at the last strobe cycle when no busy is pending.
	wire logic capture = !cur.write && (state != ST_IDLE) &&
		(next_state == ST_DONE);
	// A read of our own mailbox has just finished.
	wire logic own_box_read = capture && is_own_box;

	// Next values of the pins; strobes only fall inside the chip select.
	wire logic next_ce_n = !active;
	wire logic [9:0] next_addr = start ? req.addr : cur.addr;
	wire logic next_rw_n = !(strobing && op_write);
	wire logic next_oe_n = !(strobing && !op_write);
	wire logic next_data_oe_n = !(active && op_write);
	wire logic [7:0] next_data_out = start ? req.wdata : cur.wdata;
	// The pin has cleared by the time an own-mailbox read ends; a new post
	// in that very cycle shows one cycle late instead of being lost.
	wire logic next_mailbox_irq = !mailbox_irq_n && !own_box_read;

	// Sequencer state and counter.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// The request is latched when taken, so the user may move on at once.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur <= '0;
		end else if (start) begin
			cur <= req;
		end
	end

	// Any busy during an access forces an extend pulse, even a short one.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			busy_seen <= 1'b0;
		end else if (state == ST_IDLE) begin
			busy_seen <= 1'b0;
		end else begin
			busy_seen <= busy_seen | busy_now;
		end
	end

	// Handshake toward the user: ready while idle, done for one cycle.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
			done <= 1'b0;
		end else begin
			req_ready <= (next_state == ST_IDLE);
			done <= (next_state == ST_DONE);
		end
	end

	// Read data and the interrupt flag toward the user.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata <= '0;
			mailbox_irq <= 1'b0;
		end else begin
			if (capture) begin
				rdata <= data_in;
			end
			mailbox_irq <= next_mailbox_irq;
		end
	end

	// Pins toward the device port; chip select holds through the access.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pins <= '{ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, addr: '0};
		end else begin
			pins <= '{ce_n: next_ce_n, rw_n: next_rw_n,
				oe_n: next_oe_n, addr: next_addr};
		end
	end

	// Slave strobe lags the address by the settle delay already, so no
	// slave byte is written before the master has arbitrated.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			slave_rw_n <= 1'b1;
		end else begin
			slave_rw_n <= next_rw_n;
		end
	end

	// Write data is driven for the whole select, never during a read.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			data_out <= '0;
			data_oe_n <= 1'b1;
		end else begin
			data_out <= next_data_out;
			data_oe_n <= next_data_oe_n;
		end
	end
endmodule : dpa_host_port

// ===== verif/dpa_host_port_properties.sv
`timescale 1ns/1ps
// Host duties at the controller pins toward the shared memory.
module dpa_host_port_properties (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic done,
	input wire dpa_pkg::dpa_pins_type pins,
	input wire logic slave_rw_n,
	input wire logic busy_n
);
	import dpa_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_wait_on_busy: assert property (
		!busy_n && !pins.ce_n |=> !done) else $error("done under busy");
	a_extend_write: assert property (
		$rose(busy_n) && !pins.rw_n |-> !pins.rw_n [*2])
		else $error("strobe cut short");
	a_slave_same_strobe: assert property (
		slave_rw_n == pins.rw_n && (slave_rw_n || !pins.ce_n))
		else $error("slave strobe differs");
	a_slave_strobe_late: assert property (
		$fell(slave_rw_n) |-> $past(pins.ce_n, 2) == 1'b0)
		else $error("slave strobe too early");
	cover property (!busy_n && !pins.ce_n);
	cover property ($fell(pins.rw_n));
	cover property ($fell(pins.oe_n));
endmodule : dpa_host_port_properties

bind dpa_host_port dpa_host_port_properties i_dpa_host_port_properties (
	.ref_clk, .rst_n, .done, .pins, .slave_rw_n, .busy_n);

// ===== verif/dpa_dev_model.sv
`timescale 1ns/1ps
// Master memory seen from the host's port; the far port is a plain bus.
module dpa_dev_model (
	input wire logic ref_clk,
	input wire dpa_pkg::dpa_pins_type pins,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	input wire logic own_top,
	input wire logic other_ce,
	input wire logic other_we,
	input wire logic [9:0] other_addr,
	input wire logic [7:0] other_data,
	output logic [7:0] data_in,
	output logic busy_n,
	output logic irq_n
);
	import dpa_pkg::*;
	logic [7:0] mem [1024];
	logic [9:0] box;
	logic rd, match, won, host_we, other_ok;
	logic match_q = 1'b0, host_sel_q = 1'b0, other_sel_q = 1'b0;
	logic host_wins = 1'b0;
	assign box = own_top ? RIGHT_MAILBOX_ADDR : LEFT_MAILBOX_ADDR;
	assign rd = !pins.ce_n && !pins.oe_n && pins.rw_n;
	// Both ports selected on one word is contention.
	assign match = !pins.ce_n && other_ce && (pins.addr == other_addr);
	// A host lead of a whole cycle wins; a tie goes to the far port.
	assign won = match_q ? host_wins : (host_sel_q && !other_sel_q);
	assign host_we = !pins.ce_n && !pins.rw_n && !data_oe_n &&
		!(match && !won);
	assign other_ok = other_ce && other_we && !(match && won);
	initial data_in = 8'h00;
	initial irq_n = 1'b1;
	initial busy_n = 1'b1;
	// Busy reaches the host only, a cycle after the match starts or ends,
	// inside the worst busy delay.
	always @(posedge ref_clk) begin
		match_q <= match;
		host_sel_q <= !pins.ce_n;
		other_sel_q <= other_ce;
		if (match && !match_q) begin
			host_wins <= won;
		end
		busy_n <= !(match && !won);
	end
	// A released or fought-over bus shows the inverse so stale data fails.
	always @(posedge ref_clk) begin
		if (host_we) begin
			mem[pins.addr] <= data_out;
		end
		if (other_ok) begin
			mem[other_addr] <= other_data;
		end
		if (other_ok && other_addr == box) begin
			irq_n <= 1'b0;
		end else if (rd && pins.addr == box) begin
			irq_n <= 1'b1;
		end
		// Reads go on under busy; a far write flows through.
		if (!rd || !data_oe_n) begin
			data_in <= ~data_in;
		end else if (other_ok && other_addr == pins.addr) begin
			data_in <= other_data;
		end else begin
			data_in <= mem[pins.addr];
		end
	end
endmodule : dpa_dev_model

// ===== verif/dpa_host_port_tb.sv
`timescale 1ns/1ps
module dpa_host_port_tb;
	import dpa_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
	logic top = 1'b1, other_we = 1'b0, other_ce = 1'b0;
	logic req_ready, done, mailbox_irq, slave_rw_n, data_oe_n, irq_n;
	logic busy_n;
	logic [7:0] rdata, data_out, data_in, other_data = '0;
	logic [9:0] other_addr = '0;
	dpa_req_type req = '0;
	dpa_pins_type pins;
	int mismatches = 0;
	int tests_run = 0;
	dpa_host_port i_dpa_host_port (.ref_clk, .rst_n, .req_valid, .req,
		.req_ready, .done, .rdata, .mailbox_irq, .pins, .slave_rw_n,
		.data_out, .data_oe_n, .data_in, .busy_n, .mailbox_irq_n(irq_n),
		.own_mailbox_is_top(top));
	dpa_dev_model i_dpa_dev_model (.ref_clk, .pins, .data_out, .data_oe_n,
		.own_top(top), .other_ce, .other_we, .other_addr, .other_data,
		.data_in, .busy_n, .irq_n);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	// Handshakes are sampled at negedges so no edge race decides them.
	task automatic xfer(input logic w, input logic [9:0] a,
		input logic [7:0] d);
		int n = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= '{w, a, d};
		do @(negedge ref_clk); while (req_ready !== 1'b1);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		do @(negedge ref_clk); while (done !== 1'b1 && ++n < 300);
		check({7'h0, n < 300}, 8'h01);
	endtask : xfer
	task automatic other_write(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		other_ce <= 1'b1;
		other_we <= 1'b1;
		other_addr <= a;
		other_data <= d;
		@(posedge ref_clk);
		other_ce <= 1'b0;
		other_we <= 1'b0;
	endtask : other_write
	// Far port holds the word first; our write loses, waits, then lands.
	task automatic t_busy;
		@(posedge ref_clk);
		other_ce <= 1'b1;
		other_we <= 1'b1;
		other_addr <= 10'h020;
		other_data <= 8'h11;
		fork
			xfer(1'b1, 10'h020, 8'h3c);
			begin
				repeat (5) @(posedge ref_clk);
				@(negedge ref_clk);
				check({7'h0, busy_n}, 8'h00);
				@(posedge ref_clk);
				other_ce <= 1'b0;
				other_we <= 1'b0;
			end
		join
		check({7'h0, busy_n}, 8'h01);
		xfer(1'b0, 10'h020, 8'h00);
		check(rdata, 8'h3c);
	endtask : t_busy
	// Far port posts to our mailbox; reading it clears the flag.
	task automatic t_mailbox(input logic t);
		logic [9:0] box;
		box = t ? 10'h3ff : 10'h3fe;
		@(posedge ref_clk);
		top <= t;
		other_write(box, 8'h5a ^ {7'h0, t});
		repeat (3) @(negedge ref_clk);
		check({7'h0, mailbox_irq}, 8'h01);
		xfer(1'b0, box, 8'h00);
		check(rdata, 8'h5a ^ {7'h0, t});
		repeat (3) @(negedge ref_clk);
		check({7'h0, mailbox_irq}, 8'h00);
	endtask : t_mailbox
	task automatic tally_and_finish;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Main sequence; the watchdog below cuts a hang short.
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		xfer(1'b1, 10'h155, 8'ha5);
		xfer(1'b0, 10'h155, 8'h00);
		check(rdata, 8'ha5);
		t_busy();
		t_mailbox(1'b1);
		t_mailbox(1'b0);
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		tally_and_finish();
	end
endmodule : dpa_host_port_tb
